/* File: asl_sram_host.sv */
// Host controller that drives the 128K x 32 byte-lane asynchronous SRAM.
// Assumes requests and pin inputs are synchronous to clock.
// How it works
// [RULE1] Memory holds 128K 32-bit words, static.
// [RULE2] Width chosen only by asserted lane selects.
// [RULE3] Host asserts four, pairs, or one select.
// [RULE4] Select n gates byte lane n-1.
// [RULE5] Upper-pair write leaves low half untouched.
// [RULE6] Write happens in select-and-strobe overlap.
// [RULE7] Read: strobe high, drive enable low.
// [RULE8] Enable and strobe high float data lines.
// [RULE9] All selects high means standby.
// [RULE10] Selects or strobe high during address changes.
// [RULE11] Address valid before selects and strobe low.
// [RULE12] Host never drives during read drive.
// [RULE13] Enable low write ends with read data.
// [RULE14] Device float beats next device drive.
// [RULE15] Read cycle lasts grade minimum at least.
// [RULE16] Data valid within grade access time.
// [RULE17] Enable to data within grade time.
// [RULE18] Write cycle lasts grade minimum at least.
// [RULE19] Strobe low for grade minimum width.
// [RULE20] Write data set up before write end.
// [RULE21] Address setup and hold may be zero.
// [RULE22] Grade parameter, cycle counts rounded up.
`timescale 1ns/1ps
`default_nettype none
module asl_sram_host #(
  parameter int GRADE = asl_pkg::GRADE_25
) (
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  input  wire logic                       reqValid,
  input  wire logic                       reqWrite,
  input  wire logic [asl_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [3:0]                 reqLaneEn,
  input  wire logic [asl_pkg::DATA_W-1:0] reqWData,
  output var  logic                       reqReady,
  output var  logic                       rspValid,
  output var  logic [asl_pkg::DATA_W-1:0] rspRData,
  output var  logic [asl_pkg::ADDR_W-1:0] memAddr,
  output var  logic [3:0]                 lane_select_n,
  output var  logic                       outDriveEnN,
  output var  logic                       writeStrobeN,
  input  wire logic [asl_pkg::DATA_W-1:0] sharedDataIn,
  output var  logic [asl_pkg::DATA_W-1:0] sharedDataOut,
  output var  logic [3:0]                 sharedDataOe
);

  // ------------------------------------------------------------------
  // Cycle counts
  // ------------------------------------------------------------------
  localparam int RD_CYC = asl_pkg::cyc_up(asl_pkg::READ_CYCLE_MIN_PS[GRADE]
    > asl_pkg::ACCESS_MAX_PS[GRADE] ? asl_pkg::READ_CYCLE_MIN_PS[GRADE]
    : asl_pkg::ACCESS_MAX_PS[GRADE]) + 1; // RULE15 RULE16 RULE22
  localparam int WP_RAW = asl_pkg::cyc_up(
    asl_pkg::WRITE_STROBE_WIDTH_MIN_PS[GRADE]);
  localparam int DS_CYC = asl_pkg::cyc_up(
    asl_pkg::WRITE_DATA_SETUP_MIN_PS[GRADE]);
  localparam int WP_CYC = (WP_RAW > DS_CYC) ? WP_RAW : DS_CYC;
  localparam int WC_CYC = asl_pkg::cyc_up(
    asl_pkg::WRITE_CYCLE_MIN_PS[GRADE]);
  localparam int WR_CYC = (WC_CYC > WP_CYC) ? WC_CYC - WP_CYC : 1;
  localparam int TA_CYC = asl_pkg::cyc_up(asl_pkg::OFF_FLOAT_MAX_PS[GRADE]);
  localparam int CNT_W  = 4;

  // A grade outside the timing table has no counts, so it is refused.
  if (GRADE < 0 || GRADE > 3) begin : g_bad_grade
    $error("GRADE must be 0 to 3.");
  end

  // Only single lanes, aligned pairs or all four are legal widths.
  function automatic logic laneLegal(input logic [3:0] en);
    return en == 4'h1 || en == 4'h2 || en == 4'h4 || en == 4'h8 ||
           en == 4'h3 || en == 4'hC || en == 4'hF;
  endfunction : laneLegal

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  asl_pkg::asl_state_t stateQ;
  logic [CNT_W-1:0]    cntQ;
  logic [3:0]          laneQ;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stateQ        <= asl_pkg::ST_IDLE;
      cntQ          <= '0;
      laneQ         <= '0;
      reqReady      <= 1'b0;
      rspValid      <= 1'b0;
      rspRData      <= '0;
      memAddr       <= '0;
      lane_select_n <= asl_pkg::LANE_IDLE;
      outDriveEnN   <= 1'b1;
      writeStrobeN  <= 1'b1;
      sharedDataOut <= '0;
      sharedDataOe  <= '0;
    end else begin
      rspValid <= 1'b0;
      case (stateQ)
        asl_pkg::ST_IDLE: begin
          reqReady <= 1'b1;
          if (reqValid && reqReady && laneLegal(reqLaneEn)) begin // RULE3
            reqReady      <= 1'b0;
            // Address goes out with the selects in the same edge. RULE11
            memAddr       <= reqAddr; // RULE21
            laneQ         <= reqLaneEn;
            lane_select_n <= ~reqLaneEn; // RULE2 RULE4
            if (reqWrite) begin
              writeStrobeN  <= 1'b0; // RULE6
              outDriveEnN   <= 1'b1;
              sharedDataOut <= reqWData; // RULE20
              sharedDataOe  <= reqLaneEn; // RULE5
              cntQ          <= CNT_W'(WP_CYC - 1);
              stateQ        <= asl_pkg::ST_WRITE;
            end else begin
              outDriveEnN  <= 1'b0; // RULE7
              writeStrobeN <= 1'b1;
              sharedDataOe <= '0; // RULE12
              cntQ         <= CNT_W'(RD_CYC - 1);
              stateQ       <= asl_pkg::ST_READ;
            end
          end
        end
        asl_pkg::ST_READ: begin
          if (cntQ == '0) begin
            // Sampled a full access time later, selects still low. RULE17
            for (int i = 0; i < asl_pkg::LANES; i++) begin
              rspRData[i*8 +: 8] <= laneQ[i] ? sharedDataIn[i*8 +: 8]
                                             : 8'h00;
            end
            rspValid      <= 1'b1;
            lane_select_n <= asl_pkg::LANE_IDLE; // RULE9
            outDriveEnN   <= 1'b1; // RULE8
            cntQ          <= CNT_W'(TA_CYC - 1);
            stateQ        <= asl_pkg::ST_TURN; // RULE14
          end else begin
            cntQ <= cntQ - 1'b1;
          end
        end
        asl_pkg::ST_WRITE: begin
          if (cntQ == '0) begin
            // Strobe and selects rise in the same edge; address stays. RULE10
            writeStrobeN  <= 1'b1;
            lane_select_n <= asl_pkg::LANE_IDLE;
            cntQ          <= CNT_W'(WR_CYC - 1);
            stateQ        <= asl_pkg::ST_WREC; // RULE18
          end else begin
            cntQ <= cntQ - 1'b1;
          end
        end
        asl_pkg::ST_WREC: begin
          sharedDataOe <= '0;
          if (cntQ == '0) begin
            stateQ <= asl_pkg::ST_IDLE;
          end else begin
            cntQ <= cntQ - 1'b1;
          end
        end
        asl_pkg::ST_TURN: begin
          // Waits out the device float time before the bus may turn.
          if (cntQ == '0) begin
            stateQ <= asl_pkg::ST_IDLE;
          end else begin
            cntQ <= cntQ - 1'b1;
          end
        end
        default: begin
          stateQ <= asl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Saturating run lengths keep the width checks short for every grade,
  // instead of long repetitions that the property engines unroll.
  logic [CNT_W-1:0] strobeLowCnt;
  logic [CNT_W-1:0] oeLowCnt;
  logic [CNT_W-1:0] oeHighCnt;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strobeLowCnt <= '0;
    end else if (writeStrobeN) begin
      strobeLowCnt <= '0;
    end else if (strobeLowCnt != '1) begin
      strobeLowCnt <= strobeLowCnt + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      oeLowCnt <= '0;
    end else if (outDriveEnN) begin
      oeLowCnt <= '0;
    end else if (oeLowCnt != '1) begin
      oeLowCnt <= oeLowCnt + 1'b1;
    end
  end

  // Starts saturated: after reset no read has left the bus floating.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      oeHighCnt <= '1;
    end else if (!outDriveEnN) begin
      oeHighCnt <= '0;
    end else if (oeHighCnt != '1) begin
      oeHighCnt <= oeHighCnt + 1'b1;
    end
  end

  AST_NO_CONTENTION: assert property ( // RULE12
    @(posedge clock) disable iff (sys_rst)
    !(outDriveEnN == 1'b0 && writeStrobeN && sharedDataOe != 4'h0))
    else $error("Host drives data while memory reads.");
  AST_ADDR_STABLE: assert property ( // RULE10
    @(posedge clock) disable iff (sys_rst)
    (memAddr != $past(memAddr)) |-> ($past(writeStrobeN)
      || $past(lane_select_n) == 4'hF))
    else $error("Address changed during a write.");
  AST_LEGAL_LANES: assert property ( // RULE3
    @(posedge clock) disable iff (sys_rst)
    lane_select_n == 4'hF || laneLegal(~lane_select_n))
    else $error("Illegal lane select pattern.");
  AST_WP_WIDTH: assert property ( // RULE19
    @(posedge clock) disable iff (sys_rst)
    $rose(writeStrobeN) |-> strobeLowCnt >= CNT_W'(WP_CYC))
    else $error("Write strobe too short.");
  AST_WDATA_HELD: assert property ( // RULE20
    @(posedge clock) disable iff (sys_rst)
    $rose(writeStrobeN) |-> $stable(sharedDataOut)
      && sharedDataOe == $past(sharedDataOe))
    else $error("Write data not held to write end.");
  AST_READ_LEN: assert property ( // RULE15
    @(posedge clock) disable iff (sys_rst)
    $rose(outDriveEnN) |-> oeLowCnt >= CNT_W'(RD_CYC))
    else $error("Read cycle too short.");
  AST_READ_RSP: assert property ( // RULE16
    @(posedge clock) disable iff (sys_rst)
    $fell(outDriveEnN) |-> ##RD_CYC rspValid)
    else $error("Read answer not on time.");
  AST_NO_RW_BOTH: assert property ( // RULE7
    @(posedge clock) disable iff (sys_rst)
    !(outDriveEnN == 1'b0 && writeStrobeN == 1'b0))
    else $error("Read and write controls both active.");
  AST_TURNAROUND: assert property ( // RULE14
    @(posedge clock) disable iff (sys_rst)
    sharedDataOe != 4'h0 |-> oeHighCnt >= CNT_W'(TA_CYC))
    else $error("Host drove before device floated.");

endmodule : asl_sram_host
`default_nettype wire

/* File: asl_pkg.sv */
// Constants for the host-side controller of a 128K x 32 byte-lane SRAM.
// Assumes a single 40 MHz system clock; no software registers.
package asl_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W  = 17;
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int CLK_PS  = 25000;

  // ------------------------------------------------------------------
  // Speed grades and timing in picoseconds
  // ------------------------------------------------------------------
  localparam int GRADE_12 = 0;
  localparam int GRADE_15 = 1;
  localparam int GRADE_20 = 2;
  localparam int GRADE_25 = 3;

  localparam int READ_CYCLE_MIN_PS [4] = '{12000, 15000, 20000, 25000};
  localparam int ACCESS_MAX_PS     [4] = '{12000, 15000, 20000, 25000};
  localparam int WRITE_CYCLE_MIN_PS[4] = '{12000, 15000, 20000, 25000};
  localparam int WRITE_STROBE_WIDTH_MIN_PS[4] = '{10000, 12000, 15000,
                                                   20000};
  localparam int WRITE_DATA_SETUP_MIN_PS[4] = '{7000, 9000, 12000, 15000};
  localparam int OFF_FLOAT_MAX_PS  [4] = '{6000, 8000, 9000, 10000};

  // Least times round up to whole cycles, never under one.
  function automatic int cyc_up(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam logic [3:0] LANE_IDLE = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_WRITE = 3'b010,
    ST_WREC  = 3'b011,
    ST_TURN  = 3'b100
  } asl_state_t;

endpackage : asl_pkg

/* File: asl_sram_model.sv */
// Behavioural model of the 128K x 32 byte-lane SRAM for the bench.
// Assumes one host on the lines; undriven lanes show a toggling pattern.
`timescale 1ns/1ps
`default_nettype none
module asl_sram_model #(
  parameter int ACCESS_NS = 25
) (
  input  wire logic        clock,
  input  wire logic [16:0] memAddr,
  input  wire logic [3:0]  lane_select_n,
  input  wire logic        outDriveEnN,
  input  wire logic        writeStrobeN,
  input  wire logic [31:0] hostOut,
  input  wire logic [3:0]  hostOe,
  output wire logic [31:0] lineLevel,
  output wire logic        contend
);
  logic [31:0] mem [0:131071];
  logic [31:0] floatPat = 32'hA5A5A5A5;
  wire  [31:0] rdWord;
  wire  [3:0]  devEn;
  // A floating line must not look like the last value.
  always @(posedge clock) floatPat <= ~floatPat;
  // Read data settles only after the access time, stale before.
  assign #(ACCESS_NS) rdWord = mem[memAddr];
  assign devEn = ~lane_select_n
    & {4{~outDriveEnN & writeStrobeN}};
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign lineLevel[8*i+:8] = hostOe[i] ? hostOut[8*i+:8] :
      devEn[i] ? rdWord[8*i+:8] : floatPat[8*i+:8];
  end
  assign contend = |(hostOe & devEn);
  always @* begin
    for (int i = 0; i < 4; i++)
      if (!writeStrobeN && !lane_select_n[i])
        mem[memAddr][8*i+:8] = lineLevel[8*i+:8];
  end
endmodule : asl_sram_model
`default_nettype wire

/* File: tb_async_sram_128kx32_lanes.sv */
// Self-checking bench: random lane-masked traffic against a reference.
// Assumes the host at grade 25 and the behavioural SRAM model.
`timescale 1ns/1ps
`default_nettype none
module tb_async_sram_128kx32_lanes;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reqValid = 1'b0;
  logic        reqWrite = 1'b0;
  logic [16:0] reqAddr = 17'h00000;
  logic [3:0]  reqLaneEn = 4'hF;
  logic [31:0] reqWData = 32'h00000000;
  logic        reqReady, rspValid, outDriveEnN, writeStrobeN, contend;
  logic [31:0] rspRData, sharedDataOut, lineLevel;
  logic [16:0] memAddr;
  logic [3:0]  lane_select_n, sharedDataOe;
  int          err_total = 0;
  int          total_checks = 0;
  int          seed;
  logic [31:0] expMem [int];
  localparam logic [3:0] LEGAL [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC,
                                       4'hF};
  // Access time in whole cycles plus one sampling margin cycle.
  localparam int RD_LAT =
    asl_pkg::cyc_up(asl_pkg::ACCESS_MAX_PS[asl_pkg::GRADE_25]) + 1;
  always #12.5 clock = ~clock;
  asl_sram_host #(.GRADE(asl_pkg::GRADE_25)) uut (
    .clock(clock), .sys_rst(sys_rst), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqLaneEn(reqLaneEn),
    .reqWData(reqWData), .reqReady(reqReady), .rspValid(rspValid),
    .rspRData(rspRData), .memAddr(memAddr), .lane_select_n(lane_select_n),
    .outDriveEnN(outDriveEnN), .writeStrobeN(writeStrobeN),
    .sharedDataIn(lineLevel), .sharedDataOut(sharedDataOut),
    .sharedDataOe(sharedDataOe));
  asl_sram_model #(.ACCESS_NS(25)) mdl (
    .clock(clock), .memAddr(memAddr), .lane_select_n(lane_select_n),
    .outDriveEnN(outDriveEnN), .writeStrobeN(writeStrobeN),
    .hostOut(sharedDataOut), .hostOe(sharedDataOe),
    .lineLevel(lineLevel), .contend(contend));
  task automatic check_val(input string what, input logic [31:0] got,
                           input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val
  task automatic check_idle();
    check_val("pins", {22'h0, lane_select_n, sharedDataOe, outDriveEnN,
              writeStrobeN}, {22'h0, 4'hF, 4'h0, 2'b11});
  endtask : check_idle
  function automatic logic [16:0] addr_of(input int k);
    return k[4] ? (17'h1FFF0 | 17'(k[3:0])) : 17'(k[3:0]);
  endfunction : addr_of
  task automatic do_req(input logic wr, input logic [16:0] a,
                        input logic [3:0] ln, input logic [31:0] d);
    int          n;
    logic [31:0] m;
    @(posedge clock);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr <= a;
    reqLaneEn <= ln;
    reqWData <= d;
    n = 0;
    @(posedge clock);
    while (reqReady !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    check_val("ready", {31'h0, reqReady}, 32'h1);
    reqValid <= 1'b0;
    for (int i = 0; i < 4; i++) m[8*i+:8] = {8{ln[i]}};
    if (wr) expMem[int'(a)] = (expMem[int'(a)] & ~m) | (d & m);
    else begin
      n = 0;
      @(posedge clock);
      while (rspValid !== 1'b1 && n < 50) begin
        @(posedge clock);
        n++;
      end
      check_val("latency", n, RD_LAT);
      check_val("read", rspRData, expMem[int'(a)] & m);
    end
  endtask : do_req
  task automatic print_verdict();
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  always @(posedge clock)
    if (!sys_rst) check_val("contention", {31'h0, contend}, 32'h0);
  initial begin
    #(25 * 20000);
    err_total++;
    print_verdict();
  end
  initial begin
    seed = $urandom(56348);
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    check_idle();
    for (int k = 0; k < 32; k++) do_req(1'b1, addr_of(k), 4'hF, $urandom());
    repeat (400) do_req(1'($urandom_range(1, 0)),
      addr_of($urandom_range(31, 0)), LEGAL[$urandom_range(6, 0)],
      $urandom());
    repeat (6) @(posedge clock);
    check_idle();
    print_verdict();
  end
endmodule : tb_async_sram_128kx32_lanes
`default_nettype wire
